/* File: common/asgp_pkg.sv */
// constants and carrier types for the analog-shared gpio ports
package asgp_pkg;
  // ==========================================================
  // register map (bank-relative offsets)
  localparam logic [7:0] ASGP_OFS_FIRST_DIR = 8'h10;
  localparam logic [7:0] ASGP_OFS_FIRST_DATA = 8'h11;
  localparam logic [7:0] ASGP_OFS_SECOND_DIR = 8'h12;
  localparam logic [7:0] ASGP_OFS_SECOND_DATA = 8'h13;
  localparam logic [7:0] ASGP_OFS_PIN_CONFIG = 8'h15;
  localparam logic [3:0] ASGP_BANK = 4'h5;
  // ==========================================================
  // reset values
  localparam logic [7:0] ASGP_DIR_RESET = 8'hFF;
  localparam logic [7:0] ASGP_FIRST_DATA_RESET = 8'h00;
  localparam logic [3:0] ASGP_SECOND_LOW_RESET = 4'h0;
  localparam logic [7:0] ASGP_PIN_CONFIG_RESET = 8'h00;
  // ==========================================================
  // converter_pin_config fields
  localparam int ASGP_CLK_SEL_HI_POS = 7;
  localparam int ASGP_CLK_SEL_LO_POS = 6;
  localparam int ASGP_JUSTIFY_POS = 5;
  localparam logic [7:0] ASGP_PIN_CONFIG_MASK = 8'hEF;
  localparam int ASGP_PIN_CFG_LSB = 0;
  localparam int ASGP_PIN_CFG_W = 4;
  // pin_cfg code n leaves channels 0..(11-n) analog; codes 12..15 none
  localparam int ASGP_CHANNELS = 12;
  localparam logic [3:0] ASGP_PIN_CFG_ALL_DIGITAL = 4'hE;
  // ==========================================================
  // channel numbers of the shared pins
  localparam int ASGP_FIRST_CH_BASE = 4;
  localparam int ASGP_SECOND_CH_TOP = 3;
  // second-port peripheral pin positions
  localparam int ASGP_CAPTURE_BIT = 4;
  localparam int ASGP_PWM_BIT = 5;
  localparam int ASGP_SERIAL_DATA_BIT = 6;
  localparam int ASGP_SERIAL_CLOCK_BIT = 7;

  // one register access from the core, same clock
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] bank_selector;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asgp_bus_s;

  // pin drive requests from the pwm and serial units
  typedef struct packed {
    logic pwm_en;
    logic third_pulse_out;
    logic tx_en;
    logic serial2_transmit;
    logic sdata_en;
    logic serial2_sync_data;
  } asgp_periph_s;
endpackage : asgp_pkg

/* File: design/asgp_ports.sv */
// two 8-bit gpio ports sharing pins with converter and peripherals
`timescale 1ns/1ps

// How it works
// - direction bit 1 makes pin input; 0 drives latch value out unless analog; enabled peripherals drive second-port bits 5..7 regardless.
// - data read returns pin levels, analog pins as zero; data write updates only latches.
// - each first-port pin can act as one converter input.
// - any reset makes all first-port pins analog until software changes.
// - first-port bits 0..7 map to converter channels 4..11.
// - second-port low nibble is analog-capable; bits 0,1 channels 3,2.
// - bit 2 is channel 1 or low reference; bit 3 channel 0 or high.
// - any reset makes second-port low four pins analog.
// - second-port bit 4 feeds capture three; bit 5 carries pwm three.
// - bits 6 and 7 carry serial two receive/data and transmit/clock.
// - these registers decode only when bank selector holds bank 5.
// - unimplemented register bits, like config bit 4, read as zero.
module asgp_ports import asgp_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire asgp_bus_s bus,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic [7:0] first_pin_in,
  output logic [7:0] first_pin_out,
  output logic [7:0] first_pin_oe,
  input wire logic [7:0] second_pin_in,
  output logic [7:0] second_pin_out,
  output logic [7:0] second_pin_oe,
  output logic [7:0] first_analog,
  output logic [3:0] second_analog,
  input wire asgp_periph_s periph,
  output logic third_capture_in,
  output logic serial2_receive,
  output logic serial2_sync_clock,
  output logic conv_clock_sel_hi,
  output logic conv_clock_sel_lo,
  output logic result_justify
);
  // ==========================================================
  // registers
  logic [7:0] first_port_direction;
  logic [7:0] first_port_data;
  logic [7:0] second_port_direction;
  logic [7:0] second_port_data;
  logic [7:0] converter_pin_config;
  logic [7:0] first_meta, first_sync;
  logic [7:0] second_meta, second_sync;
  logic bank_ok;
  logic [3:0] pin_cfg;
  logic [11:0] chan_analog;
  logic [7:0] next_first_analog;
  logic [3:0] next_second_analog;
  logic [7:0] next_first_out, next_first_oe;
  logic [7:0] next_second_out, next_second_oe;
  logic [7:0] first_read, second_read;
  logic [7:0] next_rdata;
  logic next_hit;

  assign bank_ok = (bus.bank_selector == ASGP_BANK);
  assign pin_cfg = converter_pin_config[ASGP_PIN_CFG_LSB +: ASGP_PIN_CFG_W];

  // ==========================================================
  // register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      first_port_direction <= ASGP_DIR_RESET;
      second_port_direction <= ASGP_DIR_RESET;
    end else if (bus.wr && bank_ok) begin
      if (bus.addr == ASGP_OFS_FIRST_DIR) begin
        first_port_direction <= bus.wdata;
      end
      if (bus.addr == ASGP_OFS_SECOND_DIR) begin
        second_port_direction <= bus.wdata;
      end
    end
  end

  // data writes land in the latches only, never in the pin readback
  always_ff @(posedge clk) begin
    if (reset) begin
      first_port_data <= ASGP_FIRST_DATA_RESET;
    end else if (bus.wr && bank_ok && bus.addr == ASGP_OFS_FIRST_DATA) begin
      first_port_data <= bus.wdata;
    end
  end

  // upper nibble keeps its value across reset, as the latch does
  always_ff @(posedge clk) begin
    if (reset) begin
      second_port_data[3:0] <= ASGP_SECOND_LOW_RESET;
    end else if (bus.wr && bank_ok && bus.addr == ASGP_OFS_SECOND_DATA) begin
      second_port_data <= bus.wdata;
    end
  end

  // reset value zero selects every shared pin as analog
  always_ff @(posedge clk) begin
    if (reset) begin
      converter_pin_config <= ASGP_PIN_CONFIG_RESET;
    end else if (bus.wr && bank_ok && bus.addr == ASGP_OFS_PIN_CONFIG) begin
      converter_pin_config <= bus.wdata & ASGP_PIN_CONFIG_MASK;
    end
  end

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge clk) begin
    first_meta <= first_pin_in;
    first_sync <= first_meta;
    second_meta <= second_pin_in;
    second_sync <= second_meta;
  end

  // ==========================================================
  // analog channel selection and pin mapping
  genvar c;
  generate
    for (c = 0; c < ASGP_CHANNELS; c++) begin : g_chan
      // channel c analog while c + code stays below the channel count
      assign chan_analog[c] =
        ({1'b0, pin_cfg} + 5'(c)) < 5'(ASGP_CHANNELS);
    end
    for (c = 0; c < 8; c++) begin : g_first
      assign next_first_analog[c] =
        chan_analog[ASGP_FIRST_CH_BASE + c];
    end
    for (c = 0; c < 4; c++) begin : g_second
      // bits 2 and 3 also carry the converter references in analog mode
      assign next_second_analog[c] =
        chan_analog[ASGP_SECOND_CH_TOP - c];
    end
  endgenerate

  // ==========================================================
  // pin drive
  always_comb begin
    // analog pins never drive, to keep the converter input clean
    next_first_oe = ~first_port_direction & ~next_first_analog;
    next_first_out = first_port_data;
    next_second_oe = ~second_port_direction
                     & {4'hF, ~next_second_analog};
    next_second_out = second_port_data;
    if (periph.pwm_en) begin
      next_second_out[ASGP_PWM_BIT] = periph.third_pulse_out;
      next_second_oe[ASGP_PWM_BIT] = 1'b1;
    end
    if (periph.sdata_en) begin
      next_second_out[ASGP_SERIAL_DATA_BIT] =
        periph.serial2_sync_data;
      next_second_oe[ASGP_SERIAL_DATA_BIT] = 1'b1;
    end
    if (periph.tx_en) begin
      next_second_out[ASGP_SERIAL_CLOCK_BIT] =
        periph.serial2_transmit;
      next_second_oe[ASGP_SERIAL_CLOCK_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      first_pin_oe <= 8'h00;
      second_pin_oe <= 8'h00;
      first_analog <= 8'hFF;
      second_analog <= 4'hF;
    end else begin
      first_pin_oe <= next_first_oe;
      second_pin_oe <= next_second_oe;
      first_analog <= next_first_analog;
      second_analog <= next_second_analog;
    end
  end

  always_ff @(posedge clk) begin
    first_pin_out <= next_first_out;
    second_pin_out <= next_second_out;
  end

  // ==========================================================
  // peripheral inputs
  always_ff @(posedge clk) begin
    if (reset) begin
      third_capture_in <= 1'b0;
      serial2_receive <= 1'b0;
      serial2_sync_clock <= 1'b0;
      conv_clock_sel_hi <= 1'b0;
      conv_clock_sel_lo <= 1'b0;
      result_justify <= 1'b0;
    end else begin
      third_capture_in <= second_sync[ASGP_CAPTURE_BIT];
      serial2_receive <= second_sync[ASGP_SERIAL_DATA_BIT];
      serial2_sync_clock <= second_sync[ASGP_SERIAL_CLOCK_BIT];
      conv_clock_sel_hi <= converter_pin_config[ASGP_CLK_SEL_HI_POS];
      conv_clock_sel_lo <= converter_pin_config[ASGP_CLK_SEL_LO_POS];
      result_justify <= converter_pin_config[ASGP_JUSTIFY_POS];
    end
  end

  // ==========================================================
  // register reads
  assign first_read = first_sync & ~next_first_analog;
  assign second_read = second_sync & {4'hF, ~next_second_analog};

  always_comb begin
    next_rdata = 8'h00;
    next_hit = bank_ok;
    case (bus.addr)
      ASGP_OFS_FIRST_DIR: next_rdata = first_port_direction;
      ASGP_OFS_FIRST_DATA: next_rdata = first_read;
      ASGP_OFS_SECOND_DIR: next_rdata = second_port_direction;
      ASGP_OFS_SECOND_DATA: next_rdata = second_read;
      ASGP_OFS_PIN_CONFIG: next_rdata = converter_pin_config;
      default: next_hit = 1'b0;
    endcase
    if (!bank_ok) begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else if (bus.rd) begin
      reg_rdata <= next_rdata;
      reg_hit <= next_hit;
    end else begin
      reg_hit <= 1'b0;
    end
  end
endmodule : asgp_ports

/* File: verification/asgp_monitor.sv */
// concurrent checks on the analog-shared gpio port boundary
`timescale 1ns/1ps
module asgp_monitor import asgp_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire asgp_bus_s bus,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic [7:0] first_pin_out,
  input wire logic [7:0] first_pin_oe,
  input wire logic [7:0] second_pin_in,
  input wire logic [7:0] second_pin_oe,
  input wire logic [7:0] second_pin_out,
  input wire logic [7:0] first_analog,
  input wire logic [3:0] second_analog,
  input wire asgp_periph_s periph,
  input wire logic third_capture_in
);
  // ==========================================================
  // helpers
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [2:0] run;
  wire hit5 = bus.bank_selector == ASGP_BANK;
  // synchroniser history is only trusted once it refilled after reset
  always_ff @(posedge clk) begin
    if (reset) run <= 3'h0;
    else if (run != 3'h4) run <= run + 3'h1;
  end
  // ==========================================================
  // properties
  oe_analog_a: assert property (
    (first_pin_oe & first_analog) == 8'h00)
    else $error("first port drives an analog pin");
  hit_bank_a: assert property (
    reg_hit |-> $past(bus.rd) && $past(hit5))
    else $error("read hit outside the selected bank");
  miss_bank_a: assert property (
    bus.rd && !hit5 |=> !reg_hit && reg_rdata == 8'h00)
    else $error("read in another bank returned data");
  reset_analog_a: assert property (disable iff (1'b0)
    reset |=> first_analog == 8'hFF && second_analog == 4'hF)
    else $error("shared pins not analog after reset");
  cfg_bit4_a: assert property (
    bus.rd && hit5 && bus.addr == ASGP_OFS_PIN_CONFIG |=> !reg_rdata[4])
    else $error("unimplemented config bit read as one");
  data_out_a: assert property (
    bus.wr && hit5 && bus.addr == ASGP_OFS_FIRST_DATA
    |-> ##2 first_pin_out == $past(bus.wdata, 2))
    else $error("first port latch not driven");
  dir_oe_a: assert property (
    bus.wr && hit5 && bus.addr == ASGP_OFS_FIRST_DIR && first_analog == 0
    |-> ##2 first_pin_oe == ~$past(bus.wdata, 2))
    else $error("first port enables differ from direction");
  pwm_drive_a: assert property (
    periph.pwm_en |=> second_pin_oe[5]
    && second_pin_out[5] == $past(periph.third_pulse_out))
    else $error("pulse output not driven on its pin");
  capture_a: assert property (
    run == 3'h4 |-> third_capture_in == $past(second_pin_in[4], 3))
    else $error("capture input does not follow its pin");
  cover property (reg_hit);
  cover property (periph.pwm_en);
  cover property (first_analog == 8'h00);
endmodule : asgp_monitor
bind asgp_ports asgp_monitor chk (.clk, .reset, .bus, .reg_rdata, .reg_hit,
  .first_pin_out, .first_pin_oe, .second_pin_in, .second_pin_oe,
  .second_pin_out, .first_analog, .second_analog, .periph,
  .third_capture_in);

/* File: verification/asgp_pins.sv */
// pin-side model: resolves driven and external levels
`timescale 1ns/1ps
module asgp_pins (
  input wire logic [7:0] first_pin_out,
  input wire logic [7:0] first_pin_oe,
  input wire logic [7:0] second_pin_out,
  input wire logic [7:0] second_pin_oe,
  input wire logic [7:0] first_ext,
  input wire logic [7:0] second_ext,
  output logic [7:0] first_pin_in,
  output logic [7:0] second_pin_in
);
  // an undriven pin shows the outside source, never the stale latch
  assign first_pin_in = first_pin_oe & first_pin_out
    | ~first_pin_oe & first_ext;
  assign second_pin_in = second_pin_oe & second_pin_out
    | ~second_pin_oe & second_ext;
endmodule : asgp_pins

/* File: verification/test_asgp_ports.sv */
// self-checking bench for the analog-shared gpio ports
`timescale 1ns/1ps
module test_asgp_ports import asgp_pkg::*; ;
  // ==========================================================
  // harness
  logic clk = 1'b0, reset = 1'b1;
  asgp_bus_s bus = '0;
  asgp_periph_s periph = '0;
  logic [7:0] first_ext = 8'hFF, second_ext = 8'hAF, reg_rdata;
  logic [7:0] first_pin_in, first_pin_out, first_pin_oe, first_analog;
  logic [7:0] second_pin_in, second_pin_out, second_pin_oe;
  logic [3:0] second_analog;
  logic reg_hit, third_capture_in, serial2_receive, serial2_sync_clock;
  logic conv_clock_sel_hi, conv_clock_sel_lo, result_justify;
  int fail_count = 0, checks = 0;
  wire [7:0] periph_in = {5'h00, third_capture_in, serial2_receive,
    serial2_sync_clock};
  wire [7:0] cfg_out = {5'h00, conv_clock_sel_hi, conv_clock_sel_lo,
    result_justify};
  always #20 clk = ~clk;
  asgp_ports uut (.clk, .reset, .bus, .reg_rdata, .reg_hit, .first_pin_in,
    .first_pin_out, .first_pin_oe, .second_pin_in, .second_pin_out,
    .second_pin_oe, .first_analog, .second_analog, .periph,
    .third_capture_in, .serial2_receive, .serial2_sync_clock,
    .conv_clock_sel_hi, .conv_clock_sel_lo, .result_justify);
  asgp_pins pins (.first_pin_out, .first_pin_oe, .second_pin_out,
    .second_pin_oe, .first_ext, .second_ext, .first_pin_in, .second_pin_in);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  // one strobe held across exactly one sampling edge
  task automatic acc(input logic w, input logic [3:0] bk,
    input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{w, !w, bk, a, d};
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    #1;
  endtask : acc
  task automatic rd(input logic [3:0] bk, input logic [7:0] a,
    input logic [7:0] exp, input logic hit);
    acc(1'b0, bk, a, 8'h00);
    chk(reg_rdata, exp);
    chk({7'h00, reg_hit}, {7'h00, hit});
  endtask : rd
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk(first_analog, 8'hFF);
    chk({4'h0, second_analog}, 8'h0F);
    chk(first_pin_oe, 8'h00);
    rd(ASGP_BANK, ASGP_OFS_FIRST_DIR, 8'hFF, 1'b1);
    rd(ASGP_BANK, ASGP_OFS_SECOND_DIR, 8'hFF, 1'b1);
    rd(ASGP_BANK, ASGP_OFS_FIRST_DATA, 8'h00, 1'b1);
    rd(ASGP_BANK, ASGP_OFS_SECOND_DATA, 8'hA0, 1'b1);
    rd(ASGP_BANK, ASGP_OFS_PIN_CONFIG, 8'h00, 1'b1);
  endtask : t_reset
  task automatic t_digital();
    acc(1'b1, ASGP_BANK, ASGP_OFS_PIN_CONFIG, 8'h0E);
    wt(2);
    chk(first_analog | {4'h0, second_analog}, 8'h00);
    acc(1'b1, ASGP_BANK, ASGP_OFS_FIRST_DATA, 8'hA5);
    acc(1'b1, ASGP_BANK, ASGP_OFS_FIRST_DIR, 8'h03);
    acc(1'b1, ASGP_BANK, ASGP_OFS_SECOND_DATA, 8'h5A);
    acc(1'b1, ASGP_BANK, ASGP_OFS_SECOND_DIR, 8'hF0);
    wt(4);
    chk(first_pin_oe, 8'hFC);
    chk(second_pin_oe, 8'h0F);
    rd(ASGP_BANK, ASGP_OFS_FIRST_DATA, 8'hA7, 1'b1);
    rd(ASGP_BANK, ASGP_OFS_SECOND_DATA, 8'hAA, 1'b1);
  endtask : t_digital
  task automatic t_bank();
    acc(1'b1, 4'h4, ASGP_OFS_FIRST_DATA, 8'h00);
    wt(3);
    chk(first_pin_out, 8'hA5);
    rd(4'h4, ASGP_OFS_FIRST_DATA, 8'h00, 1'b0);
    rd(ASGP_BANK, 8'h14, 8'h00, 1'b0);
  endtask : t_bank
  task automatic t_config();
    logic [3:0] code[3] = '{4'h1, 4'h4, 4'h9};
    logic [7:0] fa[3] = '{8'h7F, 8'h0F, 8'h00};
    logic [3:0] sa[3] = '{4'hF, 4'hF, 4'hE};
    acc(1'b1, ASGP_BANK, ASGP_OFS_PIN_CONFIG, 8'hFF);
    rd(ASGP_BANK, ASGP_OFS_PIN_CONFIG, 8'hEF, 1'b1);
    chk(cfg_out, 8'h07);
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, ASGP_BANK, ASGP_OFS_PIN_CONFIG, {4'h0, code[i]});
      wt(2);
      chk(first_analog, fa[i]);
      chk({4'h0, second_analog}, {4'h0, sa[i]});
      chk(first_pin_oe, 8'hFC & ~fa[i]);
    end
    acc(1'b1, ASGP_BANK, ASGP_OFS_PIN_CONFIG, 8'h0E);
  endtask : t_config
  task automatic t_periph();
    @(posedge clk);
    second_ext <= 8'h5F;
    wt(5);
    chk(periph_in, 8'h06);
    @(posedge clk);
    periph <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    wt(3);
    chk(second_pin_oe, 8'hEF);
    chk(second_pin_out & 8'hE0, 8'h60);
    @(posedge clk);
    periph <= '0;
    // upper pins must drive from the direction register alone
    acc(1'b1, ASGP_BANK, ASGP_OFS_SECOND_DIR, 8'h00);
    wt(4);
    chk(second_pin_oe, 8'hFF);
    rd(ASGP_BANK, ASGP_OFS_SECOND_DATA, 8'h5A, 1'b1);
  endtask : t_periph
  task automatic t_rereset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    wt(2);
    chk(first_analog, 8'hFF);
    chk({4'h0, second_analog}, 8'h0F);
    chk(first_pin_oe | second_pin_oe, 8'h00);
    rd(ASGP_BANK, ASGP_OFS_PIN_CONFIG, 8'h00, 1'b1);
    rd(ASGP_BANK, ASGP_OFS_SECOND_DATA, 8'h50, 1'b1);
  endtask : t_rereset
  // ==========================================================
  // run control
  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    wt(2);
    t_reset();
    t_digital();
    t_bank();
    t_config();
    t_periph();
    t_rereset();
    end_of_test();
  end
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
endmodule : test_asgp_ports
